/* File: src/uas_aux_regs.vh */
`ifndef UAS_AUX_REGS_VH
`define UAS_AUX_REGS_VH

// register byte offsets
`define UAS_ADDR_W 8
`define UAS_OFF_EFR 8'h00
`define UAS_OFF_SPECIAL 8'h04
`define UAS_OFF_LCR 8'h08
`define UAS_OFF_IER 8'h0C
`define UAS_OFF_DIVLO 8'h10
`define UAS_OFF_DIVHI 8'h14
`define UAS_OFF_MCR 8'h18
`define UAS_OFF_EXTRA_FEATURE_CTRL_REG 8'h1C
`define UAS_OFF_ISR 8'h20
`define UAS_OFF_MSR 8'h24
`define UAS_OFF_STATUS 8'h28

// field positions
`define UAS_EFR_SPECIAL_BIT 5
`define UAS_ISR_SPECIAL_BIT 4
`define UAS_ISR_NOINT_BIT 0
`define UAS_IER_SLEEP_BIT 4
`define UAS_MCR_DTR_BIT 0
`define UAS_MCR_RTS_BIT 1
`define UAS_MCR_LOOP_BIT 4
`define UAS_MCR_IR_BIT 6
`define UAS_EXTRA_FEATURE_CTRL_REG_IRX_BIT 7

// reset values
`define UAS_REG_RESET 8'h00
`define UAS_ISR_RESET 8'h01

// word length codes and compare masks
`define UAS_WL5 2'h0
`define UAS_WL6 2'h1
`define UAS_WL7 2'h2
`define UAS_MASK5 8'h1F
`define UAS_MASK6 8'h3F
`define UAS_MASK7 8'h7F
`define UAS_MASK8 8'hFF

// timing
`define UAS_CLK_HZ 25000000
`define UAS_CLK_PERIOD_NS 40
`define UAS_PUMP_WAKE_NS 45000
`define UAS_PUMP_IDLE_S 30

// bus answers
`define UAS_RESP_OKAY 2'h0
`define UAS_RESP_SLVERR 2'h2

`endif

/* File: src/uas_aux_top.v */
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "uas_aux_regs.vh"
`default_nettype none
module uas_aux_top #(
	parameter IR_CHANNEL = 1,
	parameter OVERSAMPLE = 16,
	parameter integer IDLE_CYCLES = `UAS_PUMP_IDLE_S * `UAS_CLK_HZ
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire rst,
	input wire clkEnable,
	// axi4-lite write
	input wire [`UAS_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [`UAS_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// uart core side
	input wire rxCharValid,
	input wire [7:0] rxChar,
	input wire txShiftOut,
	input wire txBitStart,
	input wire sampleTick,
	input wire txActive,
	input wire thrWrite,
	input wire coreIntPending,
	input wire peerSleepReady,
	output reg rxSerialToCore_q,
	output reg [3:0] modemToCore_q,
	output wire autoFlowAllowed,
	output wire sleepReady,
	// serial and modem pins
	input wire rxPin,
	input wire ctsPin_n,
	input wire dsrPin_n,
	input wire riPin_n,
	input wire cdPin_n,
	input wire charge_pump_autosleep_pin,
	output reg txPin_q,
	output reg rtsPin_n_q,
	output reg dtrPin_n_q,
	// power control
	output wire oscillator_output_pin,
	output wire pumpEnable,
	output wire driverOe_n,
	output wire fullSleep
);
	localparam [1:0] PUMP_ON = 2'b00;
	localparam [1:0] PUMP_OFF = 2'b01;
	localparam [1:0] PUMP_WAKE = 2'b10;
	localparam integer WAKE_CYC =
		(`UAS_PUMP_WAKE_NS + `UAS_CLK_PERIOD_NS - 1) / `UAS_CLK_PERIOD_NS;
	localparam [31:0] WAKE_LAST_W = WAKE_CYC - 1;
	localparam [31:0] IDLE_LAST_W = IDLE_CYCLES - 1;
	// counter widths cover the documented counts
	localparam [10:0] WAKE_LAST = WAKE_LAST_W[10:0];
	localparam [29:0] IDLE_LAST = IDLE_LAST_W[29:0];

	// software registers
	reg [7:0] enhanced_feature_reg_q;
	reg [7:0] special_char_reg_q;
	reg [7:0] line_control_reg_q;
	reg [7:0] interrupt_enable_reg_q;
	reg [7:0] divisor_low_reg_q;
	reg [7:0] divisor_high_reg_q;
	reg [7:0] modem_control_reg_q;
	reg [7:0] extra_feature_ctrl_reg_q;
	reg specialHit_q;
	reg [3:0] modemDelta_q;
	// bus state
	reg awHave_q;
	reg wHave_q;
	reg [`UAS_ADDR_W-1:0] awAddr_q;
	reg [7:0] wByte_q;
	reg wLane_q;
	// power state
	reg asleep_q;
	reg [1:0] pumpState_q;
	reg pumpFull_q;
	reg [10:0] wakeCnt_q;
	reg [29:0] idleCnt_q;
	// edge history
	reg [3:0] modemPrev_q;
	reg rxPrev_q;

	wire [3:0] modemSync;
	wire [1:0] miscSync;
	wire rxSync;
	wire acpSync;
	wire irTx;
	wire irRx;
	wire loopOn;
	wire irOn;
	wire rxStart;
	wire rxIdle;
	wire [3:0] modemChange;
	wire modemRise;
	wire wakeEvent;
	wire intPending;
	wire localReady;
	wire wrFire;
	wire arFire;
	wire wrMapped;
	wire isrRead;
	wire msrRead;
	reg [7:0] charMask;
	reg [7:0] rdByte;
	reg rdMapped;

	// pin synchronisers: cts, dsr, ri, cd and rx, autosleep
	uas_sync2 #(.W(4)) uModemSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.clkEnable(clkEnable),
		.asyncIn({cdPin_n, riPin_n, dsrPin_n, ctsPin_n}),
		.syncOut(modemSync),
		.resetLevel(4'hF)
	);
	uas_sync2 #(.W(2)) uMiscSync (
		.clk_sys(clk_sys),
		.rst(rst),
		.clkEnable(clkEnable),
		.asyncIn({charge_pump_autosleep_pin, rxPin}),
		.syncOut(miscSync),
		.resetLevel(2'h3)
	);
	assign rxSync = miscSync[0];
	assign acpSync = miscSync[1];

	// mode decode
	assign loopOn = modem_control_reg_q[`UAS_MCR_LOOP_BIT];
	assign irOn = (IR_CHANNEL != 0) & modem_control_reg_q[`UAS_MCR_IR_BIT];

	// infrared encoder and decoder
	uas_ir_codec #(.OVERSAMPLE(OVERSAMPLE)) uIrCodec (
		.clk_sys(clk_sys),
		.rst(rst),
		.clkEnable(clkEnable),
		.irOn(irOn),
		.extMode(extra_feature_ctrl_reg_q[`UAS_EXTRA_FEATURE_CTRL_REG_IRX_BIT]),
		.sampleTick(sampleTick),
		.txBitStart(txBitStart),
		.txData(txShiftOut),
		.rxSynced(rxSync),
		.irTx_q(irTx),
		.rxDecoded_q(irRx)
	);

	// line activity: idle level is low in infrared, high otherwise
	assign rxIdle = irOn ? ~rxSync : rxSync;
	assign rxStart = irOn ? (rxSync & ~rxPrev_q) : (~rxSync & rxPrev_q);
	assign modemChange = loopOn ? 4'h0 : (modemSync ^ modemPrev_q);
	assign modemRise = |(modemChange & modemSync);

	always @(posedge clk_sys) begin
		if (rst) begin
			rxPrev_q <= 1'b1;
			modemPrev_q <= 4'hF;
		end else if (clkEnable) begin
			rxPrev_q <= rxSync;
			modemPrev_q <= modemSync;
		end
	end

	// word length mask for the special character compare
	always @* begin
		case (line_control_reg_q[1:0])
			`UAS_WL5: charMask = `UAS_MASK5;
			`UAS_WL6: charMask = `UAS_MASK6;
			`UAS_WL7: charMask = `UAS_MASK7;
			default: charMask = `UAS_MASK8;
		endcase
	end

	// bus handshakes
	assign s_axi_awready = ~awHave_q & ~s_axi_bvalid;
	assign s_axi_wready = ~wHave_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wrFire = awHave_q & wHave_q & ~s_axi_bvalid;
	assign arFire = s_axi_arvalid & s_axi_arready;
	assign wrMapped = (awAddr_q <= `UAS_OFF_EXTRA_FEATURE_CTRL_REG) && (awAddr_q[1:0] == 2'h0);
	assign isrRead = arFire && (s_axi_araddr == `UAS_OFF_ISR);
	assign msrRead = arFire && (s_axi_araddr == `UAS_OFF_MSR);

	// write channel capture and response
	always @(posedge clk_sys) begin
		if (rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= `UAS_OFF_EFR;
			wByte_q <= `UAS_REG_RESET;
			wLane_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UAS_RESP_OKAY;
		end else if (clkEnable) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHave_q <= 1'b1;
				wByte_q <= s_axi_wdata[7:0];
				wLane_q <= s_axi_wstrb[0];
			end
			if (wrFire) begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? `UAS_RESP_OKAY : `UAS_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable registers
	always @(posedge clk_sys) begin
		if (rst) begin
			enhanced_feature_reg_q <= `UAS_REG_RESET;
			special_char_reg_q <= `UAS_REG_RESET;
			line_control_reg_q <= `UAS_REG_RESET;
			interrupt_enable_reg_q <= `UAS_REG_RESET;
			divisor_low_reg_q <= `UAS_REG_RESET;
			divisor_high_reg_q <= `UAS_REG_RESET;
			modem_control_reg_q <= `UAS_REG_RESET;
			extra_feature_ctrl_reg_q <= `UAS_REG_RESET;
		end else if (clkEnable && wrFire && wLane_q) begin
			case (awAddr_q)
				`UAS_OFF_EFR: enhanced_feature_reg_q <= wByte_q;
				`UAS_OFF_SPECIAL: special_char_reg_q <= wByte_q;
				`UAS_OFF_LCR: line_control_reg_q <= wByte_q;
				`UAS_OFF_IER: interrupt_enable_reg_q <= wByte_q;
				`UAS_OFF_DIVLO: divisor_low_reg_q <= wByte_q;
				`UAS_OFF_DIVHI: divisor_high_reg_q <= wByte_q;
				`UAS_OFF_MCR: modem_control_reg_q <= wByte_q;
				`UAS_OFF_EXTRA_FEATURE_CTRL_REG: extra_feature_ctrl_reg_q <= wByte_q;
				default: ;
			endcase
		end
	end

	// sticky event flags, hardware set wins over read clear
	always @(posedge clk_sys) begin
		if (rst) begin
			specialHit_q <= 1'b0;
			modemDelta_q <= 4'h0;
		end else if (clkEnable) begin
			if (rxCharValid && enhanced_feature_reg_q[`UAS_EFR_SPECIAL_BIT] &&
				((rxChar & charMask) == (special_char_reg_q & charMask))) begin
				specialHit_q <= 1'b1;
			end else if (isrRead) begin
				specialHit_q <= 1'b0;
			end
			if (msrRead) begin
				modemDelta_q <= modemChange;
			end else begin
				modemDelta_q <= modemDelta_q | modemChange;
			end
		end
	end

	// read data mux
	always @* begin
		rdByte = 8'h00;
		rdMapped = 1'b1;
		case (s_axi_araddr)
			`UAS_OFF_EFR: rdByte = enhanced_feature_reg_q;
			`UAS_OFF_SPECIAL: rdByte = special_char_reg_q;
			`UAS_OFF_LCR: rdByte = line_control_reg_q;
			`UAS_OFF_IER: rdByte = interrupt_enable_reg_q;
			`UAS_OFF_DIVLO: rdByte = divisor_low_reg_q;
			`UAS_OFF_DIVHI: rdByte = divisor_high_reg_q;
			`UAS_OFF_MCR: rdByte = modem_control_reg_q;
			`UAS_OFF_EXTRA_FEATURE_CTRL_REG: rdByte = extra_feature_ctrl_reg_q;
			`UAS_OFF_ISR: rdByte = {3'h0, specialHit_q, 3'h0, ~intPending};
			`UAS_OFF_MSR: rdByte = {~modemSync, modemDelta_q};
			`UAS_OFF_STATUS: rdByte = {3'h0, pumpState_q == PUMP_ON, fullSleep,
				pumpEnable, sleepReady, asleep_q};
			default: rdMapped = 1'b0;
		endcase
	end

	// read channel
	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `UAS_RESP_OKAY;
		end else if (clkEnable) begin
			if (arFire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rdByte};
				s_axi_rresp <= rdMapped ? `UAS_RESP_OKAY : `UAS_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// uart sleep conditions for this channel
	assign intPending = specialHit_q | (|modemDelta_q) | coreIntPending;
	assign localReady = ~intPending &
		({divisor_high_reg_q, divisor_low_reg_q} != 16'h0000) &
		interrupt_enable_reg_q[`UAS_IER_SLEEP_BIT] & (modemDelta_q == 4'h0) &
		rxIdle & ~txActive;
	assign sleepReady = localReady;
	assign wakeEvent = rxStart | thrWrite | (|modemChange);

	// uart sleep: re-entered whenever both channels are ready and no wake event is present
	always @(posedge clk_sys) begin
		if (rst) begin
			asleep_q <= 1'b0;
		end else if (clkEnable) begin
			if (wakeEvent) begin
				asleep_q <= 1'b0;
			end else begin
				asleep_q <= localReady & peerSleepReady;
			end
		end
	end
	assign oscillator_output_pin = ~asleep_q;

	// charge pump idle timer
	always @(posedge clk_sys) begin
		if (rst) begin
			idleCnt_q <= 30'h0000_0000;
		end else if (clkEnable) begin
			if (pumpState_q != PUMP_ON || !acpSync || txActive || thrWrite ||
				(|modemChange) || (modemSync != 4'h0) || rxStart) begin
				idleCnt_q <= 30'h0000_0000;
			end else if (idleCnt_q != IDLE_LAST) begin
				idleCnt_q <= idleCnt_q + 30'h0000_0001;
			end
		end
	end

	// charge pump sequencer
	always @(posedge clk_sys) begin
		if (rst) begin
			pumpState_q <= PUMP_ON;
			pumpFull_q <= 1'b0;
			wakeCnt_q <= 11'h000;
		end else if (clkEnable) begin
			case (pumpState_q)
				PUMP_ON: begin
					if (acpSync && asleep_q) begin
						pumpState_q <= PUMP_OFF;
						pumpFull_q <= 1'b1;
					end else if (acpSync && idleCnt_q == IDLE_LAST) begin
						pumpState_q <= PUMP_OFF;
						pumpFull_q <= 1'b0;
					end
				end
				PUMP_OFF: begin
					if (!acpSync || rxStart || thrWrite || modemRise ||
						(pumpFull_q && !asleep_q)) begin
						pumpState_q <= PUMP_WAKE;
						pumpFull_q <= 1'b0;
						wakeCnt_q <= 11'h000;
					end else if (asleep_q) begin
						pumpFull_q <= 1'b1;
					end
				end
				PUMP_WAKE: begin
					if (wakeCnt_q == WAKE_LAST) begin
						pumpState_q <= PUMP_ON;
					end else begin
						wakeCnt_q <= wakeCnt_q + 11'h001;
					end
				end
				default: pumpState_q <= PUMP_ON;
			endcase
		end
	end
	assign pumpEnable = pumpState_q != PUMP_OFF;
	assign driverOe_n = pumpState_q != PUMP_ON;
	assign fullSleep = (pumpState_q == PUMP_OFF) & pumpFull_q & asleep_q;

	// serial path, loopback and pin hold
	assign autoFlowAllowed = ~loopOn;
	always @(posedge clk_sys) begin
		if (rst) begin
			txPin_q <= 1'b1;
			rtsPin_n_q <= 1'b1;
			dtrPin_n_q <= 1'b1;
			rxSerialToCore_q <= 1'b1;
			modemToCore_q <= 4'hF;
		end else if (clkEnable) begin
			if (loopOn) begin
				rxSerialToCore_q <= txShiftOut;
			end else begin
				txPin_q <= irOn ? irTx : txShiftOut;
				rtsPin_n_q <= ~modem_control_reg_q[`UAS_MCR_RTS_BIT];
				dtrPin_n_q <= ~modem_control_reg_q[`UAS_MCR_DTR_BIT];
				rxSerialToCore_q <= irOn ? ~irRx : rxSync;
				modemToCore_q <= modemSync;
			end
		end
	end
endmodule
`default_nettype wire

/* File: src/uas_ir_codec.v */
`timescale 1ns/1ps
`default_nettype none
module uas_ir_codec #(
	parameter OVERSAMPLE = 16
) (
	// clocking
	input wire clk_sys,
	input wire rst,
	input wire clkEnable,
	// mode
	input wire irOn,
	input wire extMode,
	// timing from baud generator
	input wire sampleTick,
	input wire txBitStart,
	// data
	input wire txData,
	input wire rxSynced,
	output reg irTx_q,
	output reg rxDecoded_q
);
	localparam [31:0] BASE_TICKS = (OVERSAMPLE * 3) / 16;
	localparam [31:0] EXT_TICKS = OVERSAMPLE / 4;
	localparam [31:0] BIT_TICKS = OVERSAMPLE;
	// counters are 8 bits wide, so keep the low byte on purpose
	localparam [7:0] BASE_W = BASE_TICKS[7:0];
	localparam [7:0] EXT_W = EXT_TICKS[7:0];
	localparam [7:0] BIT_W = BIT_TICKS[7:0];

	reg [7:0] txCnt_q;
	reg txZero_q;
	reg [7:0] rxCnt_q;
	reg rxPrev_q;
	wire [7:0] pulseW;

	assign pulseW = extMode ? EXT_W : BASE_W;

	// encoder: high pulse of 3/16 or 1/4 bit for each zero bit
	always @(posedge clk_sys) begin
		if (rst) begin
			txCnt_q <= 8'h00;
			txZero_q <= 1'b0;
			irTx_q <= 1'b0;
		end else if (clkEnable) begin
			if (txBitStart) begin
				txCnt_q <= 8'h00;
				txZero_q <= ~txData;
			end else if (sampleTick && txCnt_q != BIT_W) begin
				txCnt_q <= txCnt_q + 8'h01;
			end
			irTx_q <= irOn & txZero_q & (txCnt_q < pulseW);
		end
	end

	// decoder: each light pulse returns a one for one bit time
	always @(posedge clk_sys) begin
		if (rst) begin
			rxCnt_q <= 8'h00;
			rxPrev_q <= 1'b0;
			rxDecoded_q <= 1'b0;
		end else if (clkEnable) begin
			rxPrev_q <= rxSynced;
			if (irOn && rxSynced && !rxPrev_q) begin
				rxCnt_q <= BIT_W;
			end else if (sampleTick && rxCnt_q != 8'h00) begin
				rxCnt_q <= rxCnt_q - 8'h01;
			end
			rxDecoded_q <= irOn & (rxCnt_q != 8'h00);
		end
	end
endmodule
`default_nettype wire

/* File: src/uas_sync2.v */
`timescale 1ns/1ps
`default_nettype none
module uas_sync2 #(
	parameter W = 1
) (
	// clocking
	input wire clk_sys,
	input wire rst,
	input wire clkEnable,
	// levels
	input wire [W-1:0] asyncIn,
	output wire [W-1:0] syncOut,
	// reset level
	input wire [W-1:0] resetLevel
);
	reg [W-1:0] meta_q;
	reg [W-1:0] stable_q;

	// two-stage synchroniser, first stage read only by the second
	always @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= resetLevel;
			stable_q <= resetLevel;
		end else if (clkEnable) begin
			meta_q <= asyncIn;
			stable_q <= meta_q;
		end
	end

	assign syncOut = stable_q;
endmodule
`default_nettype wire

/* File: tb/uas_aux_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uas_aux_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clkEnable,
	// core side
	input wire logic txShiftOut,
	input wire logic thrWrite,
	input wire logic coreIntPending,
	input wire logic peerSleepReady,
	input wire logic sleepReady,
	input wire logic autoFlowAllowed,
	input wire logic rxSerialToCore_q,
	input wire logic [3:0] modemToCore_q,
	// pins and power
	input wire logic charge_pump_autosleep_pin,
	input wire logic txPin_q,
	input wire logic rtsPin_n_q,
	input wire logic dtrPin_n_q,
	input wire logic oscillator_output_pin,
	input wire logic pumpEnable,
	input wire logic driverOe_n,
	input wire logic fullSleep,
	// write response
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || !clkEnable);
	// pump coming back, and loopback held over two cycles
	sequence sPumpBack;
		$rose(pumpEnable);
	endsequence
	sequence sLoopHeld;
		!autoFlowAllowed ##1 !autoFlowAllowed;
	endsequence
	a_full_sleep_off: assert property (fullSleep |-> !pumpEnable && !oscillator_output_pin)
		else $error("full sleep with pump or oscillator on");
	a_pump_pin_low: assert property (!charge_pump_autosleep_pin [*6] |-> pumpEnable)
		else $error("pump off while autosleep pin low");
	a_drv_settle: assert property (sPumpBack |-> driverOe_n [*8])
		else $error("drivers enabled before pump settled");
	a_drv_need_pump: assert property (!driverOe_n |-> pumpEnable)
		else $error("drivers on with pump off");
	a_loop_route: assert property (sLoopHeld |-> rxSerialToCore_q == $past(txShiftOut))
		else $error("loopback data not routed");
	a_loop_pins_held: assert property (sLoopHeld |-> $stable({txPin_q, rtsPin_n_q, dtrPin_n_q})
		&& $stable(modemToCore_q))
		else $error("pins or modem moved in loopback");
	a_pend_awake: assert property (coreIntPending |=> oscillator_output_pin)
		else $error("asleep with interrupt pending");
	a_peer_awake: assert property (!peerSleepReady |=> oscillator_output_pin)
		else $error("asleep while other channel busy");
	a_tx_wakes: assert property (thrWrite |=> oscillator_output_pin)
		else $error("no wake after tx load");
	a_sleep_entry: assert property ((sleepReady && peerSleepReady && !thrWrite) [*2]
		|-> !oscillator_output_pin)
		else $error("not asleep with conditions met");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp))
		else $error("write response dropped");
endmodule
bind uas_aux_top uas_aux_sva i_uas_aux_sva (.*);
`default_nettype wire

/* File: tb/uas_aux_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uas_aux_regs.vh"
module uas_aux_top_bench;
	// design inputs
	logic clk_sys = 1'b0, rst = 1'b1, clkEnable = 1'b1, txActive = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rxChar = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF, modemLevel = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rxCharValid = 1'b0;
	logic txShiftOut = 1'b1, txBitStart = 1'b0, sampleTick = 1'b0, thrWrite = 1'b0;
	logic coreIntPending = 1'b0, peerSleepReady = 1'b1, charge_pump_autosleep_pin = 1'b0;
	logic startReq = 1'b0;
	logic [4:0] tc = 5'h00;
	// design outputs and pins
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] modemToCore_q;
	wire rxSerialToCore_q, autoFlowAllowed, sleepReady, txPin_q, rtsPin_n_q, dtrPin_n_q;
	wire oscillator_output_pin, pumpEnable, driverOe_n, fullSleep;
	wire rxPin, ctsPin_n, dsrPin_n, riPin_n, cdPin_n;
	int mismatches = 0, checked = 0;
	int mdl[8];

	uas_aux_top #(.IDLE_CYCLES(200)) i_uas_aux_top (.*);
	uas_remote_model i_uas_remote_model (.*);

	// 25 MHz clock
	always #20 clk_sys = !clk_sys;
	// oversample tick every 2 cycles, bit start every 16 ticks
	always @(posedge clk_sys) begin
		tc <= tc + 5'h01;
		sampleTick <= tc[0];
		txBitStart <= (tc == 5'h1F);
	end

	task automatic complete_run();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic timeOut();
		mismatches++;
		complete_run();
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus transfer, write or read, held until taken
	task automatic axi(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		logic aH, wH, got;
		int n;
		got = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		while (!got && n < 100) begin
			@(negedge clk_sys);
			aH = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
			wH = s_axi_wvalid && s_axi_wready;
			got = wr ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge clk_sys);
			if (aH) begin
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (wH) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
		if (!got) timeOut();
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0] r;
		axi(1'b1, a, d, q, r);
		check("wr resp", r, `UAS_RESP_OKAY);
	endtask
	task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		axi(1'b0, a, 8'h00, q, r);
		check(nm, q & m, e);
		check("rd resp", r, `UAS_RESP_OKAY);
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return oscillator_output_pin;
			1: return pumpEnable;
			2: return driverOe_n;
			default: return fullSleep;
		endcase
	endfunction
	// bounded wait for a power output to reach a level
	task automatic waitSig(input int k, input logic v, input int lim, output int n);
		n = 0;
		while (n < lim) begin
			@(negedge clk_sys);
			if (sig(k) === v) break;
			n++;
		end
		@(posedge clk_sys);
		if (n >= lim) timeOut();
	endtask

	initial begin
		int n, e, r;
		logic [7:0] x;
		logic [31:0] q;
		logic [1:0] rs;
		logic [2:0] hp;
		r = $urandom(3843);
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		// reset values, then random write and read back
		for (int i = 0; i < 10; i++) rreg("reset", 8'(4 * i), 32'h0000_00FF, (i == 8) ? 1 : 0);
		for (int i = 0; i < 8; i++) begin
			mdl[i] = $urandom & ((i == 3) ? 8'hEF : (i == 6) ? 8'hAF : 8'hFF);
			wreg(8'(4 * i), 8'(mdl[i]));
		end
		for (int i = 0; i < 8; i++) rreg("reg", 8'(4 * i), 32'h0000_00FF, mdl[i]);
		check("rts dtr", {rtsPin_n_q, dtrPin_n_q}, {!mdl[6][1], !mdl[6][0]});
		for (int i = 0; i < 8; i++) wreg(8'(4 * i), 8'h00);
		axi(1'b1, 8'h30, 8'h5A, q, rs);
		check("wr unmapped", rs, `UAS_RESP_SLVERR);
		axi(1'b0, 8'h2C, 8'h00, q, rs);
		check("rd unmapped", q, 32'h0000_0000);
		check("rd unmapped resp", rs, `UAS_RESP_SLVERR);
		// special character per word length, last pass disabled
		for (int j = 0; j < 5; j++) begin
			r = $urandom;
			wreg(`UAS_OFF_LCR, 8'(j & 3));
			wreg(`UAS_OFF_EFR, (j < 4) ? 8'h20 : 8'h00);
			wreg(`UAS_OFF_SPECIAL, 8'(r));
			for (int k = 0; k < 2; k++) begin
				x = (k ? 8'h10 : 8'h20) << (j & 3);
				rxChar <= 8'(r) ^ x;
				rxCharValid <= 1'b1;
				@(posedge clk_sys);
				rxCharValid <= 1'b0;
				rreg("special", `UAS_OFF_ISR, 32'h0000_0010, (k == 0 && j < 4) ? 32'h10 : 0);
			end
		end
		wreg(`UAS_OFF_EFR, 8'h00);
		// sleep entry, wake on tx load, rx start and modem change
		wreg(`UAS_OFF_DIVLO, 8'h01);
		wreg(`UAS_OFF_IER, 8'h10);
		waitSig(0, 1'b0, 50, n);
		rreg("status", `UAS_OFF_STATUS, 32'h0000_0003, 32'h0000_0003);
		thrWrite <= 1'b1;
		@(posedge clk_sys);
		thrWrite <= 1'b0;
		waitSig(0, 1'b1, 3, n);
		waitSig(0, 1'b0, 50, n);
		startReq <= 1'b1;
		waitSig(0, 1'b1, 8, n);
		startReq <= 1'b0;
		waitSig(0, 1'b0, 80, n);
		modemLevel <= 4'hE;
		waitSig(0, 1'b1, 8, n);
		repeat (30) @(negedge clk_sys);
		check("msr pending", oscillator_output_pin, 1'b1);
		@(posedge clk_sys);
		rreg("msr", `UAS_OFF_MSR, 32'h0000_00FF, 32'h0000_0011);
		waitSig(0, 1'b0, 50, n);
		for (int k = 0; k < 2; k++) begin
			coreIntPending <= (k == 1);
			peerSleepReady <= (k == 1);
			waitSig(0, 1'b1, 4, n);
			coreIntPending <= 1'b0;
			peerSleepReady <= 1'b1;
			waitSig(0, 1'b0, 50, n);
		end
		// full sleep and its exit, then drivers settle time
		charge_pump_autosleep_pin <= 1'b1;
		waitSig(3, 1'b1, 10, n);
		rreg("full", `UAS_OFF_STATUS, 32'h0000_001F, 32'h0000_000B);
		charge_pump_autosleep_pin <= 1'b0;
		waitSig(1, 1'b1, 10, n);
		waitSig(2, 1'b0, 1300, n);
		check("settle", n >= 1120 && n <= 1126, 1'b1);
		wreg(`UAS_OFF_IER, 8'h00);
		repeat (20) @(negedge clk_sys);
		check("awake", oscillator_output_pin, 1'b1);
		@(posedge clk_sys);
		// idle pump shutdown and restart on modem rise
		charge_pump_autosleep_pin <= 1'b1;
		modemLevel <= 4'h0;
		waitSig(1, 1'b0, 600, n);
		@(negedge clk_sys);
		check("drv off", driverOe_n, 1'b1);
		@(posedge clk_sys);
		modemLevel <= 4'h1;
		waitSig(1, 1'b1, 10, n);
		charge_pump_autosleep_pin <= 1'b0;
		modemLevel <= 4'hF;
		waitSig(2, 1'b0, 1300, n);
		rreg("msr clr", `UAS_OFF_MSR, 32'h0000_00F0, 32'h0000_0000);
		// infrared widths: base zero, extended zero, base one
		for (int m = 0; m < 3; m++) begin
			wreg(`UAS_OFF_EXTRA_FEATURE_CTRL_REG, (m == 1) ? 8'h80 : 8'h00);
			wreg(`UAS_OFF_MCR, 8'h40);
			txShiftOut <= (m == 2);
			for (int w = 0; w < 64 && tc != 5'h10; w++) @(posedge clk_sys);
			e = 0;
			repeat (128) begin
				@(negedge clk_sys);
				e += (txPin_q === 1'b1);
			end
			@(posedge clk_sys);
			check("ir width", e, (m == 0) ? 24 : (m == 1) ? 32 : 0);
		end
		wreg(`UAS_OFF_MCR, 8'h00);
		wreg(`UAS_OFF_EXTRA_FEATURE_CTRL_REG, 8'h00);
		txShiftOut <= 1'b1;
		// loopback routes the shifter and freezes pins
		wreg(`UAS_OFF_MCR, 8'h10);
		hp = {txPin_q, rtsPin_n_q, dtrPin_n_q};
		for (int i = 0; i < 20; i++) begin
			x[0] = $urandom;
			txShiftOut <= x[0];
			modemLevel <= 4'(i);
			@(posedge clk_sys);
			@(negedge clk_sys);
			check("loop rx", rxSerialToCore_q, x[0]);
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		check("loop pins", {txPin_q, rtsPin_n_q, dtrPin_n_q, modemToCore_q}, {hp, 4'hF});
		check("loop flow", autoFlowAllowed, 1'b0);
		// clock enable low freezes the loopback path
		@(posedge clk_sys);
		clkEnable <= 1'b0;
		txShiftOut <= ~x[0];
		repeat (4) @(negedge clk_sys);
		check("freeze", rxSerialToCore_q, x[0]);
		@(posedge clk_sys);
		txShiftOut <= x[0];
		@(posedge clk_sys);
		clkEnable <= 1'b1;
		repeat (2) @(posedge clk_sys);
		complete_run();
	end
endmodule
`default_nettype wire

/* File: tb/uas_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uas_remote_model (
	// clock
	input wire logic clk_sys,
	// requests from the bench
	input wire logic startReq,
	input wire logic [3:0] modemLevel,
	// line side
	output logic rxPin,
	output logic ctsPin_n,
	output logic dsrPin_n,
	output logic riPin_n,
	output logic cdPin_n
);
	// line idles marking, modem lines inactive
	initial begin
		rxPin = 1'b1;
		{cdPin_n, riPin_n, dsrPin_n, ctsPin_n} = 4'hF;
	end
	// pins change just after the edge
	always @(posedge clk_sys) begin
		rxPin <= !startReq;
		{cdPin_n, riPin_n, dsrPin_n, ctsPin_n} <= modemLevel;
	end
endmodule
`default_nettype wire
